//--- rtl/sar_defs.vh
// Contract
// - Convert start request yields 16-bit result.
// - Approximation bits drive data pins and DAC.
// - Trial bits MSB first, keep per comparator.
// - Convert start request raises busy flag.
// - Gated clock runs exactly 17 cycles while busy.
// - Start trailing edge initializes bits, busy, inhibit.
// - First step clears MSB, sets others.
// - Each step decides bit, clears next lower.
// - Busy clears after final bit decision.
// - Busy clear forces gated clock low.
// - Each bit changes on its deciding clock edge.
// - Result bits are driven negative-true.
// - Coding complementary binary or offset binary.
`ifndef SAR_DEFS_VH
`define SAR_DEFS_VH

`define SAR_WIDTH 16
`define SAR_STEP_W 5
`define SAR_FIRST_STEP 5'h00
`define SAR_LAST_STEP 5'h10
`define SAR_STEP_ONE 5'h01
`define SAR_INIT_BITS 16'hFFFF
`define SAR_FIRST_TRIAL 16'h7FFF
`define SAR_LEVEL_ZERO 1'b1
`define SAR_LEVEL_ONE 1'b0

`define SAR_ST_IDLE 2'h0
`define SAR_ST_ARMED 2'h1
`define SAR_ST_RUN 2'h2
`define SAR_ST_TAIL 2'h3

`define SAR_CLK_PERIOD_NS 100
`define SAR_DATA_SETUP_NS 20
`define SAR_SETUP_CYC ((`SAR_DATA_SETUP_NS + `SAR_CLK_PERIOD_NS - 1) / `SAR_CLK_PERIOD_NS)
`define SAR_SETUP_W 4
`define SAR_SETUP_ZERO 4'h0
`define SAR_SETUP_ONE 4'h1

`endif

//--- rtl/sar_sync2.v
`timescale 1ns/1ps
// Two-stage synchronizer for levels arriving from outside the ref_clk domain.
module sar_sync2 #(
	parameter WIDTH = 1
) (
	input wire ref_clk,
	input wire srst,
	input wire [WIDTH-1:0] async_in,
	output reg [WIDTH-1:0] sync_out
);

reg [WIDTH-1:0] stage1;

always @(posedge ref_clk) begin
	if (srst) begin
		stage1 <= {WIDTH{1'b0}};
		sync_out <= {WIDTH{1'b0}};
	end else begin
		stage1 <= async_in;
		sync_out <= stage1;
	end
end

endmodule

//--- rtl/sar_edge.v
`timescale 1ns/1ps
// Finds rising and falling edges of an already synchronized level.
module sar_edge (
	input wire ref_clk,
	input wire srst,
	input wire level,
	output wire rise,
	output wire fall
);

reg prev;

always @(posedge ref_clk) begin
	if (srst) begin
		prev <= 1'b0;
	end else begin
		prev <= level;
	end
end

assign rise = level & ~prev;
assign fall = ~level & prev;

endmodule

//--- rtl/sar_conv_seq.v
`timescale 1ns/1ps
`include "sar_defs.vh"
// Sequencer of a 16-bit successive-approximation converter.
// The start, clock and comparator pins are synchronized to ref_clk before use; the conversion
// clock pin is sampled and its edges pace the bit steps.
module sar_conv_seq (
	input wire ref_clk,
	input wire srst,
	input wire convert_start,
	input wire osc_clk,
	input wire comparator_keep,
	output reg busy,
	output reg gated_clk,
	output reg [`SAR_WIDTH-1:0] data_out,
	output reg [`SAR_WIDTH-1:0] dac_bits,
	output wire result_bit_msb,
	output wire result_bit_lsb,
	output reg start_ignored
);

wire start_s;
wire osc_s;
wire comp_s;
wire start_rise;
wire start_fall;
wire osc_rise;
wire osc_fall;

reg [1:0] state;
reg [1:0] next_state;
reg [`SAR_STEP_W-1:0] step;
reg [`SAR_STEP_W-1:0] next_step;
reg [`SAR_WIDTH-1:0] sar;
reg [`SAR_WIDTH-1:0] next_sar;
wire [`SAR_WIDTH-1:0] step_sar;
wire [`SAR_WIDTH-1:0] decide_hit;
wire [`SAR_WIDTH-1:0] trial_hit;
wire tail_done;
reg next_busy;
reg next_gated_clk;
reg next_start_ignored;
reg [`SAR_SETUP_W-1:0] setup_cnt;
reg [`SAR_SETUP_W-1:0] next_setup_cnt;

localparam [31:0] SETUP_CYC_FULL = `SAR_SETUP_CYC;
localparam [`SAR_SETUP_W-1:0] SETUP_CYC = SETUP_CYC_FULL[`SAR_SETUP_W-1:0];
localparam [1:0] ST_IDLE = `SAR_ST_IDLE;
localparam [1:0] ST_ARMED = `SAR_ST_ARMED;
localparam [1:0] ST_RUN = `SAR_ST_RUN;
localparam [1:0] ST_TAIL = `SAR_ST_TAIL;
localparam [`SAR_WIDTH-1:0] FIRST_TRIAL = `SAR_FIRST_TRIAL;

sar_sync2 #(
	.WIDTH(3)
) u_sync (
	.ref_clk(ref_clk),
	.srst(srst),
	.async_in({convert_start, osc_clk, comparator_keep}),
	.sync_out({start_s, osc_s, comp_s})
);

sar_edge u_start_edge (
	.ref_clk(ref_clk),
	.srst(srst),
	.level(start_s),
	.rise(start_rise),
	.fall(start_fall)
);

sar_edge u_osc_edge (
	.ref_clk(ref_clk),
	.srst(srst),
	.level(osc_s),
	.rise(osc_rise),
	.fall(osc_fall)
);

// Per-bit next value for one clock step of the approximation.
// A bit is held as its pin level, so a trial one is driven low and a
// rejected bit returns high.
genvar gi;
generate
	for (gi = 0; gi < `SAR_WIDTH; gi = gi + 1) begin : g_bit
		localparam [31:0] DECIDE_FULL = `SAR_WIDTH - gi;
		localparam [31:0] TRIAL_FULL = `SAR_WIDTH - 1 - gi;
		localparam [`SAR_STEP_W-1:0] DECIDE_STEP = DECIDE_FULL[`SAR_STEP_W-1:0];
		localparam [`SAR_STEP_W-1:0] TRIAL_STEP = TRIAL_FULL[`SAR_STEP_W-1:0];
		assign decide_hit[gi] = (step == DECIDE_STEP);
		// The top bit has no trial step of its own; the first step sets it.
		if (gi < `SAR_WIDTH - 1) begin : g_trial
			assign trial_hit[gi] = (step == TRIAL_STEP);
		end else begin : g_top
			assign trial_hit[gi] = 1'b0;
		end
		// Keep leaves the trial one in place, reject drops it back to zero.
		assign step_sar[gi] = (step == `SAR_FIRST_STEP) ? FIRST_TRIAL[gi] :
			decide_hit[gi] ? (comp_s ? sar[gi] : `SAR_LEVEL_ZERO) :
			trial_hit[gi] ? `SAR_LEVEL_ONE : sar[gi];
	end
endgenerate

assign tail_done = (state == ST_TAIL) && (osc_fall || !gated_clk) && (setup_cnt == SETUP_CYC);

// Sequence control: the state, the step reached and the data setup timer.
always @* begin
	next_state = state;
	next_step = step;
	next_setup_cnt = setup_cnt;
	case (state)
		ST_IDLE: begin
			if (start_rise) begin
				next_state = ST_ARMED;
			end
		end
		ST_ARMED: begin
			if (start_fall) begin
				// The trailing edge sets up the register, step count and releases the inhibit.
				next_step = `SAR_FIRST_STEP;
				next_state = ST_RUN;
			end
		end
		ST_RUN: begin
			if (osc_rise) begin
				next_step = step + `SAR_STEP_ONE;
				if (step == `SAR_LAST_STEP) begin
					next_setup_cnt = `SAR_SETUP_ZERO;
					next_state = ST_TAIL;
				end
			end
		end
		ST_TAIL: begin
			if (setup_cnt != SETUP_CYC) begin
				next_setup_cnt = setup_cnt + `SAR_SETUP_ONE;
			end
			if (tail_done) begin
				next_state = ST_IDLE;
			end
		end
		default: begin
			next_state = ST_IDLE;
			next_step = `SAR_FIRST_STEP;
			next_setup_cnt = `SAR_SETUP_ZERO;
		end
	endcase
end

// Approximation register: loaded at the trailing edge, stepped on each sampled clock rise during the run.
always @* begin
	next_sar = sar;
	case (state)
		ST_ARMED: begin
			if (start_fall) begin
				next_sar = `SAR_INIT_BITS;
			end
		end
		ST_RUN: begin
			if (osc_rise) begin
				next_sar = step_sar;
			end
		end
		default: begin
			next_sar = sar;
		end
	endcase
end

// Status flag, gated clock and the ignored-start pulse.
always @* begin
	next_busy = busy;
	next_gated_clk = gated_clk;
	next_start_ignored = 1'b0;
	case (state)
		ST_IDLE: begin
			next_gated_clk = 1'b0;
			if (start_rise) begin
				next_busy = 1'b1;
			end
		end
		ST_ARMED: begin
			next_gated_clk = 1'b0;
			if (start_fall) begin
				next_busy = 1'b1;
			end
		end
		ST_RUN: begin
			if (start_rise) begin
				next_start_ignored = 1'b1;
			end
			if (osc_rise) begin
				next_gated_clk = 1'b1;
			end else if (osc_fall) begin
				next_gated_clk = 1'b0;
			end
		end
		ST_TAIL: begin
			if (start_rise) begin
				next_start_ignored = 1'b1;
			end
			if (osc_fall || !gated_clk) begin
				next_gated_clk = 1'b0;
			end
			// Busy drops with the last clock pulse, never before the data setup time has passed.
			if (tail_done) begin
				next_busy = 1'b0;
				next_gated_clk = 1'b0;
			end
		end
		default: begin
			next_busy = 1'b0;
			next_gated_clk = 1'b0;
		end
	endcase
end

always @(posedge ref_clk) begin
	if (srst) begin
		state <= ST_IDLE;
		step <= `SAR_FIRST_STEP;
		setup_cnt <= `SAR_SETUP_ZERO;
	end else begin
		state <= next_state;
		step <= next_step;
		setup_cnt <= next_setup_cnt;
	end
end

always @(posedge ref_clk) begin
	if (srst) begin
		sar <= `SAR_INIT_BITS;
	end else begin
		sar <= next_sar;
	end
end

always @(posedge ref_clk) begin
	if (srst) begin
		busy <= 1'b0;
		gated_clk <= 1'b0;
		start_ignored <= 1'b0;
	end else begin
		busy <= next_busy;
		gated_clk <= next_gated_clk;
		start_ignored <= next_start_ignored;
	end
end

// The register is mirrored onto the pins and the feedback DAC in the
// same cycle. Pin levels are negative-true; whether the code is complementary
// or offset binary depends only on the analog range wiring.
always @(posedge ref_clk) begin
	if (srst) begin
		data_out <= `SAR_INIT_BITS;
		dac_bits <= `SAR_INIT_BITS;
	end else begin
		data_out <= next_sar;
		dac_bits <= next_sar;
	end
end

assign result_bit_msb = data_out[`SAR_WIDTH-1];
assign result_bit_lsb = data_out[0];

endmodule

//--- test/sar_conv_chk.sv
`timescale 1ns/1ps
module sar_conv_chk (
	input wire ref_clk,
	input wire srst,
	input wire convert_start,
	input wire busy,
	input wire gated_clk,
	input wire [15:0] data_out,
	input wire [15:0] dac_bits,
	input wire start_ignored
);
	reg [4:0] n_rise;
	reg gclk_q;
	always @(posedge ref_clk) begin
		gclk_q <= gated_clk;
		if (srst || !busy) n_rise <= 5'h00;
		else if (gated_clk && !gclk_q) n_rise <= n_rise + 5'h01;
	end
	default clocking @(posedge ref_clk); endclocking
	default disable iff (srst);
	a_dac_mirror: assert property (dac_bits == data_out) else $error("dac differs");
	a_start_busy: assert property ($rose(convert_start) && !busy |-> ##[2:4] busy) else $error("no busy");
	a_clk_idle: assert property (!busy |-> !gated_clk) else $error("clock runs idle");
	a_data_idle: assert property ($changed(data_out) |-> busy) else $error("data moved idle");
	a_done_setup: assert property ($fell(busy) |-> $stable(data_out) && !gated_clk) else $error("end");
	a_count_pulses: assert property ($fell(busy) |-> n_rise == 5'h11) else $error("pulse count");
	a_first_trial: assert property ($rose(gated_clk) && n_rise == 5'h00 |-> data_out == 16'h7FFF)
		else $error("first trial");
	a_next_clear: assert property ($rose(gated_clk) && n_rise != 5'h00 && n_rise < 5'h10
		|-> !data_out[4'hF - n_rise[3:0]]) else $error("next bit");
	a_ignore_busy: assert property (start_ignored |-> $past(busy)) else $error("ignore idle");
	c_start: cover property ($rose(busy));
	c_done: cover property ($fell(busy));
	c_step: cover property ($rose(gated_clk));
endmodule
bind sar_conv_seq sar_conv_chk i_chk (.ref_clk(ref_clk), .srst(srst), .convert_start(convert_start),
	.busy(busy), .gated_clk(gated_clk), .data_out(data_out), .dac_bits(dac_bits),
	.start_ignored(start_ignored));

//--- test/sar_host_model.sv
`timescale 1ns/1ps
module sar_host_model (
	input wire busy,
	input wire [15:0] data_out,
	input wire [15:0] target,
	output reg osc_clk,
	output reg comparator_keep,
	output reg [15:0] captured,
	output reg [15:0] captured_twos
);
	integer k;
	initial begin
		osc_clk = 1'b0;
		comparator_keep = 1'b0;
		captured = 16'h0000;
		captured_twos = 16'h0000;
	end
	// The clock stands low outside a conversion and stops once busy drops.
	always @(posedge busy) begin
		#1050;
		for (k = 0; k < 17 && busy; k = k + 1) begin
			osc_clk = 1'b1;
			#400;
			osc_clk = 1'b0;
			comparator_keep = (k < 16) ? target[15 - k] : 1'b0;
			#400;
		end
	end
	always @(negedge busy) begin
		captured = data_out;
		captured_twos = data_out ^ 16'h8000;
	end
endmodule

//--- test/tb.sv
`timescale 1ns/1ps
module tb;
	reg ref_clk = 1'b0;
	reg srst = 1'b1;
	reg convert_start = 1'b0;
	reg [15:0] target = 16'h0000;
	wire osc_clk, comparator_keep, busy, gated_clk, start_ignored, result_bit_msb, result_bit_lsb;
	wire [15:0] data_out, dac_bits, captured, captured_twos;
	integer n_mismatch = 0, n_tests = 0, n_ign = 0, i;
	reg [31:0] rows [0:3];
	always #50 ref_clk = ~ref_clk;
	always @(posedge ref_clk) if (start_ignored === 1'b1) n_ign = n_ign + 1;
	sar_conv_seq i_sar_conv_seq (.ref_clk(ref_clk), .srst(srst), .convert_start(convert_start),
		.osc_clk(osc_clk), .comparator_keep(comparator_keep), .busy(busy), .gated_clk(gated_clk),
		.data_out(data_out), .dac_bits(dac_bits), .result_bit_msb(result_bit_msb), .result_bit_lsb(result_bit_lsb),
		.start_ignored(start_ignored));
	sar_host_model i_sar_host_model (.busy(busy), .data_out(data_out), .target(target),
		.osc_clk(osc_clk), .comparator_keep(comparator_keep), .captured(captured), .captured_twos(captured_twos));
	task chk(input string nm, input [15:0] exp, input [15:0] got);
	begin
		n_tests = n_tests + 1;
		if (got !== exp) begin
			n_mismatch = n_mismatch + 1;
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
		end
	end
	endtask
	task conclude;
	begin
		$display("mismatches %0d checks %0d", n_mismatch, n_tests);
		if (n_mismatch == 0 && n_tests > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	end
	endtask
	task pulse;
	begin
		convert_start <= 1'b1;
		repeat (5) @(posedge ref_clk);
		convert_start <= 1'b0;
	end
	endtask
	// Mode 1 repeats the start mid-run, mode 2 resets mid-run.
	task conv(input integer mode);
		integer w;
	begin
		@(posedge ref_clk);
		pulse;
		chk("busy", 16'h0001, {15'h0000, busy});
		repeat (4) @(posedge ref_clk);
		chk("init", 16'hFFFF, data_out);
		repeat (50) @(posedge ref_clk);
		if (mode == 1) pulse;
		if (mode == 2) begin
			srst <= 1'b1;
			repeat (3) @(posedge ref_clk);
			srst <= 1'b0;
		end
		w = 0;
		while (busy !== 1'b0 && w < 400) begin
			@(posedge ref_clk);
			w = w + 1;
		end
		@(posedge ref_clk);
	end
	endtask
	initial begin
		rows[0] = {16'h0000, 16'hFFFF};
		rows[1] = {16'hFFFF, 16'h0000};
		rows[2] = {16'hA5C3, 16'h5A3C};
		rows[3] = {16'h8001, 16'h7FFE};
		repeat (8) @(posedge ref_clk);
		srst <= 1'b0;
		for (i = 0; i < 4; i = i + 1) begin
			target <= rows[i][31:16];
			conv(0);
			chk("result", rows[i][15:0], captured);
			chk("dac", rows[i][15:0], dac_bits);
			chk("ends", {14'h0000, rows[i][15], rows[i][0]}, {14'h0000, result_bit_msb, result_bit_lsb});
			chk("twos", rows[i][15:0] ^ 16'h8000, captured_twos);
		end
		target <= 16'h3C96;
		conv(1);
		chk("ignored", 16'h0001, n_ign[15:0]);
		chk("result", 16'hC369, captured);
		conv(2);
		chk("idle", 16'h0000, {14'h0000, busy, gated_clk});
		chk("reset_data", 16'hFFFF, data_out);
		target <= 16'h1234;
		conv(0);
		chk("recover", 16'hEDCB, captured);
		repeat (20) @(posedge ref_clk);
		conclude;
	end
	initial begin
		#1000000;
		n_mismatch = n_mismatch + 1;
		conclude;
	end
endmodule
